// ---- rtl/motion_pkg.sv ----
// Package of register map, field layouts, timing and carrier types for the
// freefall/motion debounce and auto-sleep block.
// Assumes a 100 MHz core clock and a simple strobe register port.
package motion_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_THRESHOLD = 8'h17;
    localparam logic [7:0] ADDR_DEBOUNCE = 8'h18;
    localparam logic [7:0] ADDR_INACTIVITY = 8'h29;
    localparam logic [7:0] ADDR_EVENT_SOURCE = 8'h16;
    localparam logic [7:0] ADDR_EVENT_CONFIG = 8'h15;
    localparam logic [7:0] ADDR_SYS_CTRL_ONE = 8'h2A;
    localparam logic [7:0] ADDR_SYS_CTRL_TWO = 8'h2B;
    localparam logic [7:0] ADDR_WAKE_SOURCE = 8'h2C;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h2D;
    localparam logic [7:0] ADDR_SYS_MODE = 8'h0B;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Field positions
    localparam int THS_MODE_BIT = 7;
    localparam int CFG_LATCH_BIT = 7;
    localparam int CFG_COMBINE_BIT = 6;
    localparam int CFG_Z_BIT = 5;
    localparam int CFG_Y_BIT = 4;
    localparam int CFG_X_BIT = 3;
    localparam int SRC_ACTIVE_BIT = 7;
    localparam int CTRL1_ACTIVE_BIT = 0;
    localparam int CTRL2_SLEEP_EN_BIT = 2;
    localparam int WAKE_FALL_BIT = 3;
    localparam int WAKE_ORIENT_BIT = 5;
    localparam int INTEN_SLEEP_BIT = 7;
    localparam int INTEN_ORIENT_BIT = 4;
    localparam int INTEN_FALL_BIT = 2;

    // Threshold scale: 0.063 g per count, samples are 10-bit at 8 g span
    localparam int SAMPLE_WIDTH = 10;
    localparam int THS_WIDTH = 7;
    localparam int THS_SHIFT = 2;
    localparam logic [SAMPLE_WIDTH-1:0] MAG_ONE = 10'h001;

    // Inactivity step times
    localparam int CLOCK_MHZ = 100;
    localparam int STEP_SHORT_MS = 320;
    localparam int STEP_LONG_MS = 640;
    localparam int STEP_SHORT_CYCLES = STEP_SHORT_MS * 1000 * CLOCK_MHZ;
    localparam int STEP_LONG_CYCLES = STEP_LONG_MS * 1000 * CLOCK_MHZ;
    localparam logic [2:0] RATE_SLOWEST = 3'h7;
    localparam logic [1:0] SLEEP_RATE_SLOWEST = 2'h3;
    localparam int STEP_WIDTH = 27;

    // Oversampling modes
    localparam logic [1:0] OSR_NORMAL = 2'h0;
    localparam logic [1:0] OSR_LOW_NOISE = 2'h1;
    localparam logic [1:0] OSR_HIGH_RES = 2'h2;
    localparam logic [1:0] OSR_LOW_POWER = 2'h3;
    // Rate codes at which a debounce step limit starts to apply
    localparam logic [2:0] RATE_400 = 3'h1;
    localparam logic [2:0] RATE_50 = 3'h4;
    localparam logic [2:0] RATE_12 = 3'h5;
    localparam logic [2:0] RATE_6 = 3'h6;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_WAKE = 3'b010,
        ST_SLEEP = 3'b100
    } power_state_e;

    typedef struct packed {
        logic [SAMPLE_WIDTH-1:0] x;
        logic [SAMPLE_WIDTH-1:0] y;
        logic [SAMPLE_WIDTH-1:0] z;
    } accel_sample_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } reg_req_s;
endpackage : motion_pkg

// ---- rtl/step_divider.sv ----
// Decimates the per-sample strobe to the debounce time step.
// Assumes sample strobes arrive one cycle wide at the effective data rate.
`default_nettype none
module step_divider
    import motion_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Control
    input wire logic sample_in,
    input wire logic [3:0] ratio_in,
    // Step out
    output logic step_out
);
    logic [3:0] count;
    logic [3:0] next_count;
    logic next_step;

    always_comb
    begin
        next_count = count;
        next_step = 1'b0;
        if (sample_in)
        begin
            if (count + 4'h1 >= ratio_in)
            begin
                next_count = 4'h0;
                next_step = 1'b1;
            end
            else
            begin
                next_count = count + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count <= 4'h0;
            step_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            count <= next_count;
            step_out <= next_step;
        end
    end
endmodule : step_divider
`default_nettype wire

// ---- rtl/motion_debounce_autosleep.sv ----
// Freefall/motion threshold detection, debounce counter and auto-wake/sleep
// inactivity timer. Registers sit on a plain strobe port.
// Assumes samples are magnitude-ready signed 10-bit words on an 8 g span.
`default_nettype none
module motion_debounce_autosleep
    import motion_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [7:0] rdata_out,
    // Samples and other detectors
    input wire logic sample_valid_in,
    input wire accel_sample_s sample_in,
    input wire logic orient_event_in,
    // Status
    output logic event_active_out,
    output logic sleeping_out,
    output logic [2:0] power_state_out,
    output logic [2:0] active_rate_out,
    output logic sleep_change_out
);
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg_req_s req;
    logic [7:0] fall_motion_threshold;
    logic [7:0] fall_motion_debounce_count;
    logic [7:0] sleep_inactivity_count;
    logic [7:0] event_config;
    logic [7:0] system_control_one;
    logic [7:0] system_control_two;
    logic [7:0] wake_source_select_register;
    logic [7:0] interrupt_enable_register;
    logic [7:0] fall_motion_event_source_register;
    logic [7:0] next_threshold;
    logic [7:0] next_debounce;
    logic [7:0] next_inactivity;
    logic [7:0] next_config;
    logic [7:0] next_ctrl_one;
    logic [7:0] next_ctrl_two;
    logic [7:0] next_wake_sel;
    logic [7:0] next_int_en;
    logic [7:0] next_rdata;
    assign req = '{addr: addr_in, wdata: wdata_in, write: write_in, read: read_in};
    logic [7:0] debounce;
    logic [7:0] next_debounce_cnt;
    logic [7:0] next_source;
    logic next_event_active;
    power_state_e state;
    power_state_e next_state;
    logic [STEP_WIDTH-1:0] step_timer;
    logic [STEP_WIDTH-1:0] next_step_timer;
    logic [7:0] inactive_steps;
    logic [7:0] next_inactive_steps;
    logic next_sleep_change;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [SAMPLE_WIDTH-1:0] magnitude(input logic [SAMPLE_WIDTH-1:0] v);
        magnitude = v[SAMPLE_WIDTH-1] ? (~v + MAG_ONE) : v;
    endfunction : magnitude

    // Debounce samples per step: a step never spans more than one sample
    function automatic logic [3:0] step_ratio(input logic [2:0] rate, input logic [1:0] osr);
        step_ratio = ((osr == OSR_HIGH_RES) && (rate > RATE_400)) ? 4'h1 : 4'h1;
    endfunction : step_ratio

    // ---------------------------------------------------------------
    // Register access
    // ---------------------------------------------------------------
    logic source_read;
    assign source_read = req.read && (req.addr == ADDR_EVENT_SOURCE);

    always_comb
    begin
        next_threshold = fall_motion_threshold;
        next_debounce = fall_motion_debounce_count;
        next_inactivity = sleep_inactivity_count;
        next_config = event_config;
        next_ctrl_one = system_control_one;
        next_ctrl_two = system_control_two;
        next_wake_sel = wake_source_select_register;
        next_int_en = interrupt_enable_register;
        next_rdata = RESET_BYTE;
        if (req.write)
        begin
            unique case (req.addr)
                ADDR_THRESHOLD: next_threshold = req.wdata;
                ADDR_DEBOUNCE: next_debounce = req.wdata;
                ADDR_INACTIVITY: next_inactivity = req.wdata;
                ADDR_EVENT_CONFIG: next_config = {req.wdata[7:3], 3'h0};
                ADDR_SYS_CTRL_ONE: next_ctrl_one = {req.wdata[7:3], 1'b0, req.wdata[1:0]};
                ADDR_SYS_CTRL_TWO: next_ctrl_two = req.wdata;
                ADDR_WAKE_SOURCE: next_wake_sel = req.wdata;
                ADDR_INT_ENABLE: next_int_en = req.wdata;
                default: ;
            endcase
        end
        if (req.read)
        begin
            unique case (req.addr)
                ADDR_THRESHOLD: next_rdata = fall_motion_threshold;
                ADDR_DEBOUNCE: next_rdata = fall_motion_debounce_count;
                ADDR_INACTIVITY: next_rdata = sleep_inactivity_count;
                ADDR_EVENT_CONFIG: next_rdata = event_config;
                ADDR_EVENT_SOURCE: next_rdata = fall_motion_event_source_register;
                ADDR_SYS_CTRL_ONE: next_rdata = system_control_one;
                ADDR_SYS_CTRL_TWO: next_rdata = system_control_two;
                ADDR_WAKE_SOURCE: next_rdata = wake_source_select_register;
                ADDR_INT_ENABLE: next_rdata = interrupt_enable_register;
                ADDR_SYS_MODE: next_rdata = {5'h00, state};
                default: next_rdata = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            fall_motion_threshold <= RESET_BYTE;
            fall_motion_debounce_count <= RESET_BYTE;
            sleep_inactivity_count <= RESET_BYTE;
            event_config <= RESET_BYTE;
            system_control_one <= RESET_BYTE;
            system_control_two <= RESET_BYTE;
            wake_source_select_register <= RESET_BYTE;
            interrupt_enable_register <= RESET_BYTE;
            rdata_out <= RESET_BYTE;
        end
        else if (clk_en_in)
        begin
            fall_motion_threshold <= next_threshold;
            fall_motion_debounce_count <= next_debounce;
            sleep_inactivity_count <= next_inactivity;
            event_config <= next_config;
            system_control_one <= next_ctrl_one;
            system_control_two <= next_ctrl_two;
            wake_source_select_register <= next_wake_sel;
            interrupt_enable_register <= next_int_en;
            rdata_out <= next_rdata;
        end
    end

    // ---------------------------------------------------------------
    // Threshold comparison
    // ---------------------------------------------------------------
    logic [SAMPLE_WIDTH-1:0] limit;
    logic [2:0] axis_high;
    logic [2:0] axis_low;
    logic [2:0] axis_en;
    logic [2:0] axis_neg;
    logic condition;
    logic [SAMPLE_WIDTH-1:0] axis_val [3];
    // Threshold counts map onto the raw 8 g scale, not the output range
    assign limit = SAMPLE_WIDTH'(fall_motion_threshold[THS_WIDTH-1:0]) << THS_SHIFT;
    assign axis_val[0] = sample_in.x;
    assign axis_val[1] = sample_in.y;
    assign axis_val[2] = sample_in.z;
    assign axis_en = {event_config[CFG_Z_BIT], event_config[CFG_Y_BIT],
                      event_config[CFG_X_BIT]};
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_axis
            assign axis_high[g] = axis_en[g] && (magnitude(axis_val[g]) > limit);
            assign axis_low[g] = !axis_en[g] || (magnitude(axis_val[g]) <= limit);
            assign axis_neg[g] = axis_val[g][SAMPLE_WIDTH-1];
        end
    endgenerate
    // Freefall needs at least one axis enabled to mean anything
    assign condition = event_config[CFG_COMBINE_BIT] ? |axis_high
                     : (&axis_low && |axis_en);

    // ---------------------------------------------------------------
    // Debounce counter and source flags
    // ---------------------------------------------------------------
    logic debounce_step;
    logic [2:0] eff_rate;
    logic [1:0] eff_osr;
    logic latched;
    assign eff_rate = (state == ST_SLEEP) ? {1'b0, system_control_one[7:6]}
                                          : system_control_one[5:3];
    assign eff_osr = (state == ST_SLEEP) ? system_control_two[4:3] : system_control_two[1:0];
    assign latched = event_config[CFG_LATCH_BIT] && fall_motion_event_source_register[SRC_ACTIVE_BIT];
    step_divider u_step (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .sample_in(sample_valid_in && (state != ST_STANDBY)),
        .ratio_in(step_ratio(eff_rate, eff_osr)),
        .step_out(debounce_step)
    );

    always_comb
    begin
        next_debounce_cnt = debounce;
        next_source = fall_motion_event_source_register;
        next_event_active = 1'b0;
        if (debounce_step)
        begin
            if (condition)
            begin
                if (debounce < fall_motion_debounce_count)
                    next_debounce_cnt = debounce + 8'h01;
            end
            else if (fall_motion_threshold[THS_MODE_BIT])
                next_debounce_cnt = RESET_BYTE;
            else if (debounce != RESET_BYTE)
                next_debounce_cnt = debounce - 8'h01;
        end
        if (source_read)
            next_source = RESET_BYTE;
        if (debounce_step && !latched)
        begin
            if (condition && (next_debounce_cnt >= fall_motion_debounce_count))
            begin
                next_source = {1'b1, 1'b0, axis_high[2], axis_neg[2], axis_high[1],
                               axis_neg[1], axis_high[0], axis_neg[0]};
                next_event_active = 1'b1;
            end
            else if (!event_config[CFG_LATCH_BIT])
                next_source = RESET_BYTE;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            debounce <= RESET_BYTE;
            fall_motion_event_source_register <= RESET_BYTE;
            event_active_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            debounce <= next_debounce_cnt;
            fall_motion_event_source_register <= next_source;
            event_active_out <= next_source[SRC_ACTIVE_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Auto wake/sleep
    // ---------------------------------------------------------------
    logic fall_wake;
    logic orient_wake;
    logic activity;
    logic [STEP_WIDTH-1:0] step_len;
    // Only orientation and freefall/motion count as activity
    assign fall_wake = next_event_active && interrupt_enable_register[INTEN_FALL_BIT]
                     && wake_source_select_register[WAKE_FALL_BIT];
    assign orient_wake = orient_event_in && interrupt_enable_register[INTEN_ORIENT_BIT]
                       && wake_source_select_register[WAKE_ORIENT_BIT];
    assign activity = fall_wake || orient_wake;
    assign step_len = (system_control_one[5:3] == RATE_SLOWEST)
                    ? STEP_WIDTH'(STEP_LONG_CYCLES - 1)
                    : STEP_WIDTH'(STEP_SHORT_CYCLES - 1);
    always_comb
    begin
        next_state = state;
        next_step_timer = step_timer;
        next_inactive_steps = inactive_steps;
        next_sleep_change = 1'b0;
        unique case (state)
            ST_STANDBY:
            begin
                next_step_timer = '0;
                next_inactive_steps = RESET_BYTE;
                if (system_control_one[CTRL1_ACTIVE_BIT])
                    next_state = ST_WAKE;
            end
            ST_WAKE:
            begin
                if (!system_control_two[CTRL2_SLEEP_EN_BIT] || activity)
                begin
                    next_step_timer = '0;
                    next_inactive_steps = RESET_BYTE;
                end
                else if (inactive_steps >= sleep_inactivity_count)
                begin
                    next_state = ST_SLEEP;
                    next_sleep_change = interrupt_enable_register[INTEN_SLEEP_BIT];
                end
                else if (step_timer >= step_len)
                begin
                    next_step_timer = '0;
                    next_inactive_steps = inactive_steps + 8'h01;
                end
                else
                    next_step_timer = step_timer + STEP_WIDTH'(1);
            end
            ST_SLEEP:
            begin
                if (activity || !system_control_two[CTRL2_SLEEP_EN_BIT])
                begin
                    next_state = ST_WAKE;
                    next_step_timer = '0;
                    next_inactive_steps = RESET_BYTE;
                    next_sleep_change = interrupt_enable_register[INTEN_SLEEP_BIT];
                end
            end
            default: next_state = ST_STANDBY;
        endcase
        // Dropping the active bit returns to standby from anywhere
        if (!system_control_one[CTRL1_ACTIVE_BIT])
            next_state = ST_STANDBY;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= ST_STANDBY;
            step_timer <= '0;
            inactive_steps <= RESET_BYTE;
            sleep_change_out <= 1'b0;
            sleeping_out <= 1'b0;
            power_state_out <= ST_STANDBY;
            active_rate_out <= 3'h0;
        end
        else if (clk_en_in)
        begin
            state <= next_state;
            step_timer <= next_step_timer;
            inactive_steps <= next_inactive_steps;
            sleep_change_out <= next_sleep_change;
            sleeping_out <= (next_state == ST_SLEEP);
            power_state_out <= next_state;
            active_rate_out <= (next_state == ST_SLEEP) ? {1'b0, system_control_one[7:6]}
                                                        : system_control_one[5:3];
        end
    end
endmodule : motion_debounce_autosleep
`default_nettype wire

// ---- verification/motion_properties.sv ----
// Port-level properties of the motion debounce and auto-sleep block.
// Assumes one clock domain and the asynchronous active-low reset.
`default_nettype none
module motion_properties
    import motion_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Observed ports
    input wire logic read_in,
    input wire logic sample_valid_in,
    input wire logic [7:0] rdata_out,
    input wire logic event_active_out,
    input wire logic sleeping_out,
    input wire logic [2:0] power_state_out,
    input wire logic [2:0] active_rate_out,
    input wire logic sleep_change_out
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_read_idle_zero:
        assert property (!$past(read_in) |-> rdata_out == 8'h00)
        else $error("read data outside its slot");
    a_state_onehot:
        assert property ($onehot(power_state_out))
        else $error("power state not one-hot");
    a_sleep_flag_match:
        assert property (sleeping_out == (power_state_out == ST_SLEEP))
        else $error("sleep flag disagrees with state");
    a_sleep_from_wake:
        assert property ($rose(sleeping_out) |-> $past(power_state_out) == ST_WAKE)
        else $error("sleep entered from standby");
    a_sleep_rate_width:
        assert property (sleeping_out |-> active_rate_out[2] == 1'b0)
        else $error("sleep rate not zero-extended");
    a_event_after_sample:
        assert property ($rose(event_active_out) |-> $past(sample_valid_in, 2))
        else $error("event rose without a sample");
    a_change_on_toggle:
        assert property (sleep_change_out |->
            ($changed(sleeping_out) || $past(sleeping_out) != $past(sleeping_out, 2)))
        else $error("sleep change pulse without toggle");
    a_standby_quiet:
        assert property (power_state_out == ST_STANDBY |-> !$rose(sleeping_out))
        else $error("sleep rose in standby");
endmodule : motion_properties

bind motion_debounce_autosleep motion_properties u_props (.mclk_in, .rst_n_in,
    .read_in, .sample_valid_in, .rdata_out, .event_active_out, .sleeping_out,
    .power_state_out, .active_rate_out, .sleep_change_out);
`default_nettype wire

// ---- verification/host_model.sv ----
// Host side of the register port: one-cycle write and read strobes.
// Assumes read data stand only in the cycle after the read strobe.
`default_nettype none
module host_model
    import motion_pkg::*;
(
    // Clock
    input wire logic mclk_in,
    // Register port
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic write_out,
    output logic read_out,
    input wire logic [7:0] rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        write_out = 1'b0;
        read_out = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_out <= a;
        wdata_out <= d;
        write_out <= 1'b1;
        @(posedge mclk_in);
        write_out <= 1'b0;
        wdata_out <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        addr_out <= a;
        read_out <= 1'b1;
        @(posedge mclk_in);
        read_out <= 1'b0;
        #1;
        d = rdata_in;
    endtask : rd
    // Control one changes only through standby
    task automatic ctrl_one(input logic [7:0] v);
        wr(ADDR_SYS_CTRL_ONE, v & 8'hFE);
        wr(ADDR_SYS_CTRL_ONE, v);
    endtask : ctrl_one
endmodule : host_model
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the motion debounce and auto-sleep block.
// Assumes host_model and the bound property checker are compiled first.
`default_nettype none
module tb
    import motion_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in, rst_n_in, write_in, read_in, sample_valid_in, orient_event_in;
    logic event_active_out, sleeping_out, sleep_change_out;
    logic [7:0] addr_in, wdata_in, rdata_out, d;
    logic [2:0] power_state_out, active_rate_out;
    logic [7:0] ra [3] = '{ADDR_THRESHOLD, ADDR_DEBOUNCE, ADDR_INACTIVITY};
    accel_sample_s sample_in;
    int miscompares, comparisons, seed, cnt, ths, lim, m, k, changes;
    initial
    begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    host_model u_host (.mclk_in, .addr_out(addr_in), .wdata_out(wdata_in),
        .write_out(write_in), .read_out(read_in), .rdata_in(rdata_out));
    motion_debounce_autosleep DUT (.mclk_in, .rst_n_in, .clk_en_in(1'b1), .addr_in,
        .wdata_in, .write_in, .read_in, .rdata_out, .sample_valid_in, .sample_in,
        .orient_event_in, .event_active_out, .sleeping_out, .power_state_out,
        .active_rate_out, .sleep_change_out);
    always @(posedge mclk_in)
        if (sleep_change_out === 1'b1)
            changes++;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic reset_dut();
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
    endtask : reset_dut
    // One sample, then the modelled debounce counter against the event flag
    task automatic send();
        int v[3];
        logic hi;
        hi = 1'b0;
        foreach (v[i])
        begin
            v[i] = $random(seed) % (ths * 4 + 20);
            hi |= (v[i] > ths * 4 || -v[i] > ths * 4);
        end
        if (m[0] ? hi : !hi)
            cnt = (cnt < lim) ? cnt + 1 : lim;
        else if (m[1])
            cnt = 0;
        else if (cnt > 0)
            cnt--;
        @(posedge mclk_in);
        sample_in <= {v[0][9:0], v[1][9:0], v[2][9:0]};
        sample_valid_in <= 1'b1;
        @(posedge mclk_in);
        sample_valid_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        #1;
        check({7'h00, event_active_out}, 8'(cnt == lim));
    endtask : send
    task automatic wait_sleep();
        for (k = 0; k < 50 && sleeping_out !== 1'b1; k++)
            @(posedge mclk_in);
        repeat (20) @(posedge mclk_in);
    endtask : wait_sleep
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        seed = 32'hecb5;
        rst_n_in = 1'b0;
        sample_valid_in = 1'b0;
        orient_event_in = 1'b0;
        sample_in = '0;
        repeat (16) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        check({5'h00, power_state_out}, 8'h01);
        foreach (ra[i])
        begin
            u_host.rd(ra[i], d);
            check(d, RESET_BYTE);
            k = $random(seed);
            u_host.wr(ra[i], k[7:0]);
            u_host.rd(ra[i], d);
            check(d, k[7:0]);
        end
        u_host.rd(8'h40, d);
        check(d, 8'h00);
        for (m = 0; m < 4; m++)
        begin
            reset_dut();
            ths = 10 + ($random(seed) & 15);
            lim = 2 + m;
            cnt = 0;
            u_host.wr(ADDR_EVENT_CONFIG, m[0] ? 8'h78 : 8'h38);
            u_host.wr(ADDR_THRESHOLD, {m[1], 7'(ths)});
            u_host.wr(ADDR_DEBOUNCE, 8'(lim));
            u_host.ctrl_one(8'h01);
            repeat (40) send();
        end
        reset_dut();
        u_host.wr(ADDR_SYS_CTRL_TWO, 8'h04);
        u_host.wr(ADDR_INT_ENABLE, 8'h90);
        u_host.wr(ADDR_WAKE_SOURCE, 8'h20);
        changes = 0;
        u_host.ctrl_one(8'hC1);
        wait_sleep();
        check({7'h00, sleeping_out}, 8'h01);
        check({5'h00, active_rate_out}, 8'h03);
        check(8'(changes), 8'h01);
        for (m = 0; m < 2; m++)
        begin
            u_host.wr(ADDR_WAKE_SOURCE, m[0] ? 8'h00 : 8'h20);
            @(posedge mclk_in);
            orient_event_in <= 1'b1;
            @(posedge mclk_in);
            orient_event_in <= 1'b0;
            wait_sleep();
            check(8'(changes), 8'h03);
        end
        reset_dut();
        u_host.ctrl_one(8'hC1);
        wait_sleep();
        check({5'h00, power_state_out}, 8'h02);
        test_done();
    end
    initial
    begin
        #200us;
        miscompares++;
        test_done();
    end
endmodule : tb
`default_nettype wire
